// file: logic/scr_defines.svh
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SCR_ADDR_W 1
`define SCR_OFS_CLOCK_AND_DIVIDER_CONTROL 1'h0
`define SCR_OFS_IRQ_TIMEBASE_WATCHDOG_CONTROL 1'h1

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define SCR_CLOCK_AND_DIVIDER_CONTROL_RESET 8'h00
`define SCR_IRQ_TIMEBASE_WATCHDOG_CONTROL_RESET 8'h8a
`define SCR_CLOCK_AND_DIVIDER_CONTROL_MASK 8'h47

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCR_BIT_CLK_SRC 0
`define SCR_BIT_XTAL_LP 1
`define SCR_BIT_DIV_PIN 2
`define SCR_BIT_DIV_CLK 6
`define SCR_EDGE_HI 7
`define SCR_EDGE_LO 6
`define SCR_TB_HI 5
`define SCR_TB_LO 4
`define SCR_WDT_HI 3
`define SCR_WDT_LO 0

// ----------------------------------------
// codes
// ----------------------------------------
`define SCR_WDT_OFF_CODE 4'ha
`define SCR_WDT_ON_CODE 4'h5
`define SCR_TB_BASE_EXP 5'h0a

`endif

// file: logic/scr_pkg.sv
package scr_pkg;
    typedef enum logic [1:0] {
        SCR_EDGE_NONE = 2'b00,
        SCR_EDGE_RISE = 2'b01,
        SCR_EDGE_FALL = 2'b10,
        SCR_EDGE_BOTH = 2'b11
    } scr_edge_t;

    typedef enum logic [1:0] {
        SCR_OSC_INTERNAL_FAST_RC_LXT = 2'b00,
        SCR_OSC_HXT = 2'b01,
        SCR_OSC_ERC = 2'b10,
        SCR_OSC_INTERNAL_FAST_RC = 2'b11
    } scr_osc_cfg_t;

    typedef enum logic [1:0] {
        SCR_INTERNAL_FAST_RC_4M = 2'b00,
        SCR_INTERNAL_FAST_RC_8M = 2'b01,
        SCR_INTERNAL_FAST_RC_12M = 2'b10,
        SCR_INTERNAL_FAST_RC_RSVD = 2'b11
    } scr_internal_fast_rc_freq_t;
endpackage

// file: logic/scr_ctl_decode.sv
`timescale 1ns/10ps
`include "scr_defines.svh"

// ----------------------------------------
// control decode from register values
// ----------------------------------------
module scr_ctl_decode (
    input wire logic [7:0] clock_and_divider_control_i,
    input wire logic [7:0] irq_timebase_watchdog_control_i,
    input wire scr_pkg::scr_osc_cfg_t osc_cfg_i,
    input wire logic wdt_cfg_on_i,
    output logic clk_from_xtal_o,
    output logic internal_fast_rc_stop_o,
    output logic wdt_run_o,
    output logic edge_rise_o,
    output logic edge_fall_o,
    output logic [4:0] tb_exp_o
);
    logic clk_sel_valid;
    logic [1:0] edge_sel;
    logic [1:0] tb_sel;

    always_comb begin
        // clock source only counts in the combined rc plus slow crystal setup
        clk_sel_valid = (osc_cfg_i == scr_pkg::SCR_OSC_INTERNAL_FAST_RC_LXT);
        clk_from_xtal_o = clk_sel_valid && clock_and_divider_control_i[`SCR_BIT_CLK_SRC];
        internal_fast_rc_stop_o = clk_from_xtal_o;
        // off only when option off and code matches exactly
        wdt_run_o = wdt_cfg_on_i ||
            (irq_timebase_watchdog_control_i[`SCR_WDT_HI:`SCR_WDT_LO] != `SCR_WDT_OFF_CODE);
        edge_sel = irq_timebase_watchdog_control_i[`SCR_EDGE_HI:`SCR_EDGE_LO];
        edge_rise_o = edge_sel[0];
        edge_fall_o = edge_sel[1];
        tb_sel = irq_timebase_watchdog_control_i[`SCR_TB_HI:`SCR_TB_LO];
        tb_exp_o = `SCR_TB_BASE_EXP + {3'h0, tb_sel};
    end
endmodule

// file: logic/scr_system_control_regs.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "scr_defines.svh"

// ----------------------------------------
// Notes on behaviour
// - slow crystal power bit 0 means quick start, 1 means low current.
// - clock source 0 runs the system from the fast rc, 1 from the slow crystal with rc off.
// - clock source only acts under the combined fast rc plus slow crystal option.
// - edge field 00 off, 01 rising, 10 falling, 11 both edges.
// - time base period is 2^10..2^13 timer clocks for codes 00..11.
// - watchdog is off only for code 1010; 0101 is the suggested enable code.
// - the always-on watchdog option overrides the enable code.
// - watchdog and time base clocks come from the oscillators besides the system clock.
// - fast rc runs at a fixed 4, 8 or 12 MHz chosen by option.
// - divider clock select 0 picks timer 0, 1 picks timer 1.
// - power-on clears the slow crystal power bit.
// ----------------------------------------
module scr_system_control_regs (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [`SCR_ADDR_W-1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire scr_pkg::scr_osc_cfg_t OSC_CFG_I,
    input wire scr_pkg::scr_internal_fast_rc_freq_t INTERNAL_FAST_RC_FREQ_CFG_I,
    input wire logic WDT_CFG_ON_I,
    input wire logic WDT_OSC_CLK_I,
    input wire logic TIMER0_OUT_I,
    input wire logic TIMER1_OUT_I,
    output logic SYS_CLK_FROM_XTAL_O,
    output logic INTERNAL_FAST_RC_STOP_O,
    output logic [1:0] INTERNAL_FAST_RC_FREQ_O,
    output logic SLOW_CRYSTAL_POWER_MODE_O,
    output logic DIVIDER_PIN_SELECT_O,
    output logic DIVIDER_CLOCK_SELECT_O,
    output logic DIVIDER_SRC_O,
    output logic WDT_RUN_O,
    output logic WDT_CLK_O,
    output logic TB_CLK_O,
    output logic IRQ_EDGE_RISE_O,
    output logic IRQ_EDGE_FALL_O,
    output logic [4:0] TB_PERIOD_EXP_O
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] clock_and_divider_control;
        logic [7:0] irq_timebase_watchdog_control;
        logic [7:0] rdata;
        logic t0_s1;
        logic t0_s2;
        logic t1_s1;
        logic t1_s2;
        logic wc_s1;
        logic wc_s2;
    } scr_state_t;

    scr_state_t st;
    scr_state_t next_st;
    logic clk_from_xtal;
    logic internal_fast_rc_stop;
    logic wdt_run;
    logic e_rise;
    logic e_fall;
    logic [4:0] tb_exp;

    scr_ctl_decode u_dec (
        .clock_and_divider_control_i(st.clock_and_divider_control),
        .irq_timebase_watchdog_control_i(st.irq_timebase_watchdog_control),
        .osc_cfg_i(OSC_CFG_I),
        .wdt_cfg_on_i(WDT_CFG_ON_I),
        .clk_from_xtal_o(clk_from_xtal),
        .internal_fast_rc_stop_o(internal_fast_rc_stop),
        .wdt_run_o(wdt_run),
        .edge_rise_o(e_rise),
        .edge_fall_o(e_fall),
        .tb_exp_o(tb_exp)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        // pins outside the clock domain pass two flops
        next_st.t0_s1 = TIMER0_OUT_I;
        next_st.t0_s2 = st.t0_s1;
        next_st.t1_s1 = TIMER1_OUT_I;
        next_st.t1_s2 = st.t1_s1;
        next_st.wc_s1 = WDT_OSC_CLK_I;
        next_st.wc_s2 = st.wc_s1;
        next_st.rdata = 8'h00;
        if (WR_I) begin
            case (ADDR_I)
                `SCR_OFS_CLOCK_AND_DIVIDER_CONTROL: begin
                    next_st.clock_and_divider_control = WDATA_I & `SCR_CLOCK_AND_DIVIDER_CONTROL_MASK;
                end
                `SCR_OFS_IRQ_TIMEBASE_WATCHDOG_CONTROL: begin
                    next_st.irq_timebase_watchdog_control = WDATA_I;
                end
                default: begin
                    next_st.clock_and_divider_control = st.clock_and_divider_control;
                end
            endcase
        end
        if (RD_I) begin
            case (ADDR_I)
                `SCR_OFS_CLOCK_AND_DIVIDER_CONTROL: begin
                    next_st.rdata = st.clock_and_divider_control;
                end
                `SCR_OFS_IRQ_TIMEBASE_WATCHDOG_CONTROL: begin
                    next_st.rdata = st.irq_timebase_watchdog_control;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
        if (RESET_I) begin
            next_st = '0;
            next_st.clock_and_divider_control = `SCR_CLOCK_AND_DIVIDER_CONTROL_RESET;
            next_st.irq_timebase_watchdog_control = `SCR_IRQ_TIMEBASE_WATCHDOG_CONTROL_RESET;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        st <= next_st;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        RDATA_O = st.rdata;
        SYS_CLK_FROM_XTAL_O = clk_from_xtal;
        INTERNAL_FAST_RC_STOP_O = internal_fast_rc_stop;
        // reserved code falls back to the lowest rate, a safe choice
        INTERNAL_FAST_RC_FREQ_O = (INTERNAL_FAST_RC_FREQ_CFG_I == scr_pkg::SCR_INTERNAL_FAST_RC_RSVD) ?
            2'h0 : INTERNAL_FAST_RC_FREQ_CFG_I;
        SLOW_CRYSTAL_POWER_MODE_O = st.clock_and_divider_control[`SCR_BIT_XTAL_LP];
        DIVIDER_PIN_SELECT_O = st.clock_and_divider_control[`SCR_BIT_DIV_PIN];
        DIVIDER_CLOCK_SELECT_O = st.clock_and_divider_control[`SCR_BIT_DIV_CLK];
        DIVIDER_SRC_O = st.clock_and_divider_control[`SCR_BIT_DIV_CLK] ? st.t1_s2 : st.t0_s2;
        WDT_RUN_O = wdt_run;
        // sampled oscillator level, so only oscillators well below 20 MHz pass
        WDT_CLK_O = st.wc_s2 && wdt_run;
        TB_CLK_O = st.wc_s2;
        IRQ_EDGE_RISE_O = e_rise;
        IRQ_EDGE_FALL_O = e_fall;
        TB_PERIOD_EXP_O = tb_exp;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_rd_clock_and_divider_control;
        RD_I && ADDR_I == `SCR_OFS_CLOCK_AND_DIVIDER_CONTROL;
    endsequence

    sequence s_wr_clock_and_divider_control;
        WR_I && ADDR_I == `SCR_OFS_CLOCK_AND_DIVIDER_CONTROL;
    endsequence

    a_unimpl_zero: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        s_rd_clock_and_divider_control |=> (RDATA_O & ~`SCR_CLOCK_AND_DIVIDER_CONTROL_MASK) == 8'h00)
        else $error("unimplemented bits read nonzero");

    a_clock_and_divider_control_write_read: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        s_wr_clock_and_divider_control ##1 (s_rd_clock_and_divider_control and !WR_I) |=>
        RDATA_O[`SCR_BIT_XTAL_LP] == $past(WDATA_I[`SCR_BIT_XTAL_LP], 2))
        else $error("power bit not read back");

    a_power_on_clear: assert property (@(posedge CLOCK_I)
        // reset code is the off code, so only the option keeps the watchdog running
        $past(RESET_I) && !RESET_I |->
        !SLOW_CRYSTAL_POWER_MODE_O && WDT_RUN_O == WDT_CFG_ON_I)
        else $error("power bit not cleared at reset");

    a_clk_src_gate: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        OSC_CFG_I != scr_pkg::SCR_OSC_INTERNAL_FAST_RC_LXT |-> !SYS_CLK_FROM_XTAL_O)
        else $error("clock source acted outside combined option");

    a_clk_src_sel: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        SYS_CLK_FROM_XTAL_O == INTERNAL_FAST_RC_STOP_O &&
        SYS_CLK_FROM_XTAL_O == (st.clock_and_divider_control[0] && OSC_CFG_I == scr_pkg::SCR_OSC_INTERNAL_FAST_RC_LXT))
        else $error("clock source select wrong");

    a_wdt_off_code: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        WR_I && ADDR_I == `SCR_OFS_IRQ_TIMEBASE_WATCHDOG_CONTROL && WDATA_I[3:0] == 4'ha && !WDT_CFG_ON_I
        ##1 !WDT_CFG_ON_I |-> !WDT_RUN_O)
        else $error("watchdog not off for disable code");

    a_wdt_forced: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        WDT_CFG_ON_I |-> WDT_RUN_O)
        else $error("watchdog option not forcing run");

    a_edge_both: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        WR_I && ADDR_I == `SCR_OFS_IRQ_TIMEBASE_WATCHDOG_CONTROL |=>
        IRQ_EDGE_RISE_O == $past(WDATA_I[6]) && IRQ_EDGE_FALL_O == $past(WDATA_I[7]))
        else $error("edge select wrong");

    a_tb_period: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        WR_I && ADDR_I == `SCR_OFS_IRQ_TIMEBASE_WATCHDOG_CONTROL |=>
        TB_PERIOD_EXP_O == 5'h0a + {3'h0, $past(WDATA_I[5:4])})
        else $error("time base period wrong");

    a_div_src: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        DIVIDER_SRC_O == (st.clock_and_divider_control[6] ? st.t1_s2 : st.t0_s2))
        else $error("divider source wrong");
endmodule

// file: testbench/scr_testbench.sv
`timescale 1ns/10ps
`include "scr_defines.svh"

module testbench;
    logic CLOCK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic [`SCR_ADDR_W-1:0] ADDR_I = '0;
    logic [7:0] WDATA_I = 8'h00;
    logic WR_I = 1'b0;
    logic RD_I = 1'b0;
    logic [7:0] RDATA_O;
    scr_pkg::scr_osc_cfg_t OSC_CFG_I = scr_pkg::SCR_OSC_INTERNAL_FAST_RC_LXT;
    scr_pkg::scr_internal_fast_rc_freq_t INTERNAL_FAST_RC_FREQ_CFG_I = scr_pkg::SCR_INTERNAL_FAST_RC_4M;
    logic WDT_CFG_ON_I = 1'b0;
    logic WDT_OSC_CLK_I = 1'b1;
    logic TIMER0_OUT_I = 1'b0;
    logic TIMER1_OUT_I = 1'b1;
    logic xtal, rc_stop, lp, pin_sel, clk_sel, div_src, wdt_run, wdt_clk, tb_clk, rise, fall;
    logic [1:0] rc_freq;
    logic [4:0] tb_exp;
    int errors = 0;
    int samples_checked = 0;

    scr_system_control_regs uut (
        .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
        .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .OSC_CFG_I(OSC_CFG_I),
        .INTERNAL_FAST_RC_FREQ_CFG_I(INTERNAL_FAST_RC_FREQ_CFG_I), .WDT_CFG_ON_I(WDT_CFG_ON_I),
        .WDT_OSC_CLK_I(WDT_OSC_CLK_I), .TIMER0_OUT_I(TIMER0_OUT_I),
        .TIMER1_OUT_I(TIMER1_OUT_I), .SYS_CLK_FROM_XTAL_O(xtal),
        .INTERNAL_FAST_RC_STOP_O(rc_stop), .INTERNAL_FAST_RC_FREQ_O(rc_freq),
        .SLOW_CRYSTAL_POWER_MODE_O(lp), .DIVIDER_PIN_SELECT_O(pin_sel),
        .DIVIDER_CLOCK_SELECT_O(clk_sel), .DIVIDER_SRC_O(div_src), .WDT_RUN_O(wdt_run),
        .WDT_CLK_O(wdt_clk), .TB_CLK_O(tb_clk), .IRQ_EDGE_RISE_O(rise),
        .IRQ_EDGE_FALL_O(fall), .TB_PERIOD_EXP_O(tb_exp)
    );

    always #12.5 CLOCK_I = ~CLOCK_I;

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // outputs are settled 1 ns after the taking edge
    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge CLOCK_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= d;
        @(posedge CLOCK_I);
        WR_I <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic a, input logic [7:0] exp, input string what);
        @(posedge CLOCK_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge CLOCK_I);
        RD_I <= 1'b0;
        #1;
        chk(what, exp, RDATA_O);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge CLOCK_I);
        RESET_I <= 1'b0;
        rd(1'b0, 8'h00, "clock_and_divider_control reset");
        rd(1'b1, 8'h8a, "irq_timebase_watchdog_control reset");
        chk("rdata stands", 8'h8a, RDATA_O);
        @(posedge CLOCK_I);
        #1;
        chk("rdata after", 8'h00, RDATA_O);
        chk("reset wdt run", 8'h00, {7'h0, wdt_run});
        $display("test reset done");
        wr(1'b0, 8'hff);
        rd(1'b0, 8'h47, "clock_and_divider_control mask");
        chk("pin sel", 8'h01, {7'h0, pin_sel});
        chk("lp mode", 8'h01, {7'h0, lp});
        wr(1'b0, 8'h00);
        chk("lp clear", 8'h00, {7'h0, lp});
        chk("pin io", 8'h00, {7'h0, pin_sel});
        for (int s = 0; s < 2; s++) begin
            wr(1'b0, {1'b0, s[0], 6'h00});
            chk("clk sel", {7'h0, s[0]}, {7'h0, clk_sel});
            chk("div src", {7'h0, s[0]}, {7'h0, div_src});
        end
        $display("test divider done");
        for (int c = 0; c < 8; c++) begin
            wr(1'b0, {7'h00, c[2]});
            OSC_CFG_I <= scr_pkg::scr_osc_cfg_t'(c[1:0]);
            INTERNAL_FAST_RC_FREQ_CFG_I <= scr_pkg::scr_internal_fast_rc_freq_t'(c[1:0]);
            @(posedge CLOCK_I);
            #1;
            chk("xtal", {7'h0, c[2] && c[1:0] == 2'b00}, {7'h0, xtal});
            chk("rc stop", {7'h0, c[2] && c[1:0] == 2'b00}, {7'h0, rc_stop});
            chk("rc freq", {6'h0, (c[1:0] == 2'b11) ? 2'b00 : c[1:0]}, {6'h0, rc_freq});
        end
        $display("test clock source done");
        for (int e = 0; e < 4; e++) begin
            wr(1'b1, {e[1:0], e[1:0], 4'h5});
            rd(1'b1, {e[1:0], e[1:0], 4'h5}, "irq_timebase_watchdog_control back");
            chk("rise", {7'h0, e[0]}, {7'h0, rise});
            chk("fall", {7'h0, e[1]}, {7'h0, fall});
            chk("tb exp", 8'd10 + 8'(e), {3'h0, tb_exp});
        end
        $display("test edge and time base done");
        for (int w = 0; w < 32; w++) begin
            WDT_CFG_ON_I <= w[4];
            wr(1'b1, {4'h8, w[3:0]});
            chk("wdt run", {7'h0, w[4] || w[3:0] != 4'ha}, {7'h0, wdt_run});
            chk("wdt clk", {7'h0, w[4] || w[3:0] != 4'ha}, {7'h0, wdt_clk});
            chk("tb clk", 8'h01, {7'h0, tb_clk});
        end
        $display("test watchdog done");
        close_out();
    end

    // about 130 cycles expected; generous margin
    initial begin
        repeat (5000) @(posedge CLOCK_I);
        errors++;
        close_out();
    end
endmodule
